/* inc/apw_cfg.svh */
/*
  Constants of the host power and watchdog supervisor: offsets, fields, times.
  Assumes a 20 MHz clock and a 32-bit APB register port.
*/
`ifndef APW_CFG_SVH
`define APW_CFG_SVH

`define APW_CLK_HZ 20000000
`define APW_TICK_HZ 32
`define APW_TICK_CYC (`APW_CLK_HZ / `APW_TICK_HZ)
`define APW_MS2TICK(ms) ((ms) * `APW_TICK_HZ / 1000)

`define APW_HOLD_LONG_MS 4000
`define APW_HOLD_SHORT_MS 250
`define APW_RST_PULSE_MS 1000
`define APW_PWR_DEF_MS 1000
`define APW_EXTEND_MS 5000
`define APW_WD_SEC_MS 1000

`define APW_CMD_OFS 8'h00
`define APW_STAT_OFS 8'h04
`define APW_CFG_OFS 8'h08

`define APW_CMD_PWRCFG 8'h1c
`define APW_CMD_WDOG 8'h1d

`define APW_MASK_RST 8'h00
`define APW_BIT_AUTOPOL 0
`define APW_BIT_RSTINV 1
`define APW_BIT_PWRINV 2
`define APW_BIT_BLANK 4
`define APW_BIT_KRST 5
`define APW_BIT_KPON 6
`define APW_BIT_KPOFF 7

`endif

/* inc/apw_pkg.sv */
/*
  Types of the host power and watchdog supervisor.
  Assumes apw_cfg.svh supplies the numeric constants.
*/
package apw_pkg;

  typedef enum logic [2:0] {
    APW_IDLE = 3'b000,
    APW_RST = 3'b001,
    APW_PON = 3'b011,
    APW_POFF = 3'b010,
    APW_PHOLD = 3'b110
  } apw_st_t;

  typedef enum logic [1:0] {
    APW_MSG_NONE = 2'h0,
    APW_MSG_RESET = 2'h1,
    APW_MSG_PON = 2'h2,
    APW_MSG_POFF = 2'h3
  } apw_msg_t;

  // Pin order: sense, confirm, cancel, reset line, power line.
  typedef struct packed {
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic sense_d;
    logic [19:0] tick_cnt;
    logic [7:0] hold_ok;
    logic [7:0] hold_cx;
    apw_st_t st;
    logic [7:0] pcnt;
    logic kp;
    logic [7:0] mask;
    logic [7:0] plen;
    logic wd_en;
    logic [7:0] wd_cnt;
    logic [4:0] wd_sub;
    logic wd_pend;
    logic rst_lvl;
    logic pwr_lvl;
    logic reboot;
    logic [31:0] prdata;
    logic pslverr;
  } apw_state_t;

endpackage

/* hw/apw_top.sv */
/*
  Host power-switch and watchdog supervisor with an APB register port.
  Assumes keys active high and both host lines pulled to their idle level.
*/
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "apw_cfg.svh"

module apw_top
  import apw_pkg::*;
#(
  parameter int TICK_CYC = `APW_TICK_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_alive_i,
  input wire logic confirm_key_i,
  input wire logic cancel_key_i,
  input wire logic host_rst_i,
  output logic host_rst_o,
  output logic host_rst_oe,
  input wire logic power_sw_i,
  output logic power_sw_o,
  output logic power_sw_oe,
  output logic display_blank,
  output apw_msg_t msg,
  output logic self_reboot
);

  localparam logic [7:0] THR_LONG = 8'(`APW_MS2TICK(`APW_HOLD_LONG_MS));
  localparam logic [7:0] THR_SHORT = 8'(`APW_MS2TICK(`APW_HOLD_SHORT_MS));
  localparam logic [7:0] RST_LEN = 8'(`APW_MS2TICK(`APW_RST_PULSE_MS));
  localparam logic [7:0] PWR_DEF = 8'(`APW_MS2TICK(`APW_PWR_DEF_MS));
  localparam logic [7:0] EXT_LEN = 8'(`APW_MS2TICK(`APW_EXTEND_MS));
  localparam logic [4:0] SEC_LAST = 5'(`APW_MS2TICK(`APW_WD_SEC_MS) - 1);
  localparam logic [19:0] TICK_LAST = 20'(TICK_CYC - 1);

  apw_state_t s, n;

  function automatic logic [7:0] hold_next(input logic [7:0] cnt, input logic key,
                                           input logic tick);
    if (!key) begin
      hold_next = 8'h00;
    end else if (tick && cnt != 8'hff) begin
      hold_next = cnt + 8'h01;
    end else begin
      hold_next = cnt;
    end
  endfunction

  function automatic logic drive_level(input logic autopol, input logic idle_lvl,
                                       input logic inv);
    drive_level = autopol ? ~idle_lvl : inv;
  endfunction

  logic sense, ok_key, cx_key, tick, acc, setup, lock, trig_kr, trig_pon, trig_poff;
  logic [7:0] ctype, d0, d1, pnext;
  logic [1:0] clen;

  always_comb begin
    n = s;
    n.sync_a = {power_sw_i, host_rst_i, cancel_key_i, confirm_key_i, host_alive_i};
    n.sync_b = s.sync_a;
    sense = s.sync_b[0];
    ok_key = s.sync_b[1];
    cx_key = s.sync_b[2];
    n.sense_d = sense;
    n.reboot = 1'b0;
    tick = (s.tick_cnt == TICK_LAST);
    n.tick_cnt = tick ? 20'h00000 : s.tick_cnt + 20'h00001;
    pnext = s.pcnt + (tick ? 8'h01 : 8'h00);

    n.hold_ok = hold_next(s.hold_ok, ok_key, tick);
    n.hold_cx = hold_next(s.hold_cx, cx_key, tick);
    trig_kr = sense && s.mask[`APW_BIT_KRST] && n.hold_ok == THR_LONG
              && s.hold_ok != THR_LONG;
    trig_pon = !sense && s.mask[`APW_BIT_KPON] && n.hold_ok == THR_SHORT
               && s.hold_ok != THR_SHORT;
    trig_poff = sense && s.mask[`APW_BIT_KPOFF] && n.hold_cx == THR_LONG
                && s.hold_cx != THR_LONG;

    // Idle levels are sampled only while floating; through sync_b our own drive still feeds back for two cycles after release.
    if (!host_rst_oe) begin
      n.rst_lvl = s.sync_b[3];
    end
    if (!power_sw_oe) begin
      n.pwr_lvl = s.sync_b[4];
    end

    if (s.wd_en && tick) begin
      if (s.wd_sub == SEC_LAST) begin
        n.wd_sub = 5'h00;
        if (s.wd_cnt == 8'h01) begin
          n.wd_cnt = 8'h00;
          n.wd_en = 1'b0;
          n.wd_pend = 1'b1;
        end else begin
          n.wd_cnt = s.wd_cnt - 8'h01;
        end
      end else begin
        n.wd_sub = s.wd_sub + 5'h01;
      end
    end

    unique case (s.st)
      APW_IDLE: begin
        n.pcnt = 8'h00;
        if (s.wd_pend) begin
          n.st = APW_RST;
          n.kp = 1'b0;
          n.wd_pend = 1'b0;
          n.tick_cnt = 20'h00000;
        end else if (trig_kr) begin
          n.st = APW_RST;
          n.kp = 1'b1;
          n.tick_cnt = 20'h00000;
        end else if (trig_pon) begin
          n.st = APW_PON;
          n.tick_cnt = 20'h00000;
        end else if (trig_poff) begin
          n.st = APW_POFF;
          n.tick_cnt = 20'h00000;
        end
      end
      APW_RST: begin
        n.pcnt = pnext;
        if (pnext == RST_LEN) begin
          n.st = APW_IDLE;
          n.reboot = s.kp;
        end
      end
      APW_PON: begin
        n.pcnt = pnext;
        if (pnext == s.plen) begin
          n.st = APW_IDLE;
          n.reboot = 1'b1;
        end
      end
      APW_POFF: begin
        n.pcnt = pnext;
        if (pnext == s.plen) begin
          n.pcnt = 8'h00;
          n.st = cx_key ? APW_PHOLD : APW_IDLE;
        end
      end
      APW_PHOLD: begin
        n.pcnt = pnext;
        if (!cx_key || pnext == EXT_LEN) begin
          n.st = APW_IDLE;
        end
      end
      default: begin
        n.st = APW_IDLE;
      end
    endcase

    if (s.mask[`APW_BIT_BLANK] && sense && !s.sense_d) begin
      n.reboot = 1'b1;
    end

    acc = psel && penable;
    setup = psel && !penable;
    ctype = pwdata[7:0];
    d0 = pwdata[15:8];
    d1 = pwdata[23:16];
    clen = pwdata[25:24];
    lock = (s.st == APW_RST) && s.kp;
    if (acc && pwrite && paddr == `APW_CMD_OFS && !lock) begin
      if (ctype == `APW_CMD_PWRCFG && (clen == 2'd1 || clen == 2'd2)) begin
        n.mask = d0;
        if (clen == 2'd2 && d1 != 8'h00) begin
          n.plen = d1;
        end
      end else if (ctype == `APW_CMD_WDOG && clen == 2'd1) begin
        n.wd_en = (d0 != 8'h00);
        n.wd_cnt = d0;
        n.wd_sub = 5'h00;
        n.wd_pend = 1'b0;
      end
    end

    // A reboot restarts the device; the stored function mask and length survive it.
    if (s.reboot) begin
      n.wd_en = 1'b0;
      n.wd_cnt = 8'h00;
      n.wd_pend = 1'b0;
      n.kp = 1'b0;
    end

    if (setup) begin
      n.pslverr = 1'b0;
      n.prdata = 32'h00000000;
      unique case (paddr)
        `APW_CMD_OFS: begin
          n.pslverr = !pwrite;
        end
        `APW_STAT_OFS: begin
          n.pslverr = pwrite;
          n.prdata = {16'h0000, lock, 1'b0, s.st, display_blank, s.wd_en, sense, s.wd_cnt};
        end
        `APW_CFG_OFS: begin
          n.pslverr = pwrite;
          n.prdata = {16'h0000, s.plen, s.mask};
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{st: APW_IDLE, mask: `APW_MASK_RST, plen: PWR_DEF, rst_lvl: 1'b1,
             pwr_lvl: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = s.pslverr;
  assign host_rst_oe = (s.st == APW_RST);
  assign host_rst_o = drive_level(s.mask[`APW_BIT_AUTOPOL], s.rst_lvl,
                                  s.mask[`APW_BIT_RSTINV]);
  assign power_sw_oe = (s.st == APW_PON) || (s.st == APW_POFF)
                       || (s.st == APW_PHOLD);
  assign power_sw_o = drive_level(s.mask[`APW_BIT_AUTOPOL], s.pwr_lvl,
                                  s.mask[`APW_BIT_PWRINV]);
  assign display_blank = s.mask[`APW_BIT_BLANK] && !s.sync_b[0];
  assign self_reboot = s.reboot;

  always_comb begin
    unique case (s.st)
      APW_RST: msg = s.kp ? APW_MSG_RESET : APW_MSG_NONE;
      APW_PON: msg = APW_MSG_PON;
      APW_POFF, APW_PHOLD: msg = APW_MSG_POFF;
      default: msg = APW_MSG_NONE;
    endcase
  end

endmodule

`default_nettype wire

/* verif/apw_top_sva.sv */
/* Checker of the host lines, messages and reboot pulse.
   Bound to apw_top; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module apw_top_sva
  import apw_pkg::*;
#(parameter int TICK_CYC = 20) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic host_alive_i,
  input wire logic confirm_key_i,
  input wire logic host_rst_o,
  input wire logic host_rst_oe,
  input wire logic power_sw_oe,
  input wire logic display_blank,
  input wire apw_msg_t msg,
  input wire logic self_reboot
);
  logic [31:0] run_r;
  // Counting pulse cycles here keeps the length check free of long repetitions.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) run_r <= 32'h0;
    else run_r <= host_rst_oe ? run_r + 32'h1 : 32'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_rst_len: assert property ($fell(host_rst_oe) |-> run_r == 32 * TICK_CYC)
    else $error("reset pulse length off");
  chk_reboot_once: assert property (self_reboot |=> !self_reboot)
    else $error("reboot pulse too long");
  chk_msg_reset: assert property (msg == APW_MSG_RESET |-> host_rst_oe)
    else $error("reset message without pulse");
  chk_rst_level: assert property (host_rst_oe && $past(host_rst_oe) |-> $stable(host_rst_o))
    else $error("reset level moved in pulse");
  chk_msg_pon: assert property (msg == APW_MSG_PON |-> power_sw_oe)
    else $error("power on message without pulse");
  chk_msg_poff: assert property (msg == APW_MSG_POFF |-> power_sw_oe)
    else $error("power off message without pulse");
  chk_key_cause: assert property ($rose(host_rst_oe) && msg == APW_MSG_RESET |-> $past(confirm_key_i, 3))
    else $error("keypad reset without key");
  chk_blank_up: assert property (host_alive_i [*4] |-> !display_blank)
    else $error("blank while host up");
  cover property ($rose(host_rst_oe));
  cover property ($rose(power_sw_oe));
  cover property (self_reboot);
endmodule
bind apw_top apw_top_sva #(.TICK_CYC(TICK_CYC)) i_sva (
  .clk(clk),
  .resetn(resetn),
  .host_alive_i(host_alive_i),
  .confirm_key_i(confirm_key_i),
  .host_rst_o(host_rst_o),
  .host_rst_oe(host_rst_oe),
  .power_sw_oe(power_sw_oe),
  .display_blank(display_blank),
  .msg(msg),
  .self_reboot(self_reboot)
);
`default_nettype wire

/* verif/apw_host_model.sv */
/* Host supply and reset circuit: pulled-up wires, sense pin, pulse meters.
   Assumes the supervisor drives a wire only while its enable is high. */
`timescale 1ns/10ps
`default_nettype none
module apw_host_model (
  input wire logic clk,
  input wire logic rst_o,
  input wire logic rst_oe,
  input wire logic pwr_o,
  input wire logic pwr_oe,
  input wire logic on,
  output logic rst_w,
  output logic pwr_w,
  output logic alive,
  output int rst_len,
  output int pwr_len,
  output int rst_cnt
);
  logic rp = 1'b0, pp = 1'b0;
  assign rst_w = rst_oe ? rst_o : 1'b1;
  assign pwr_w = pwr_oe ? pwr_o : 1'b1;
  assign alive = on;
  initial begin
    rst_len = 0;
    pwr_len = 0;
    rst_cnt = 0;
  end
  always @(posedge clk) begin
    rst_len <= (rst_oe && !rp) ? 1 : rst_len + int'(rst_oe);
    rst_cnt <= rst_cnt + int'(rst_oe && !rp);
    pwr_len <= (pwr_oe && !pp) ? 1 : pwr_len + int'(pwr_oe);
    rp <= rst_oe;
    pp <= pwr_oe;
  end
endmodule
`default_nettype wire

/* verif/testbench.sv */
/* Bench of the supervisor: APB commands, keys and host sense.
   Assumes a short tick of 20 clocks and the host model beside it. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import apw_pkg::*;
  localparam int TC = 20;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, ok_key = 1'b0, x_key = 1'b0, on = 1'b0;
  logic rst_o, rst_oe, rst_w, pwr_o, pwr_oe, pwr_w, alive, blank, reboot;
  apw_msg_t msg;
  int error_cnt = 0, total_checks = 0, n, rst_len, pwr_len, rst_cnt;
  apw_top #(.TICK_CYC(TC)) i_dut (.clk(clk), .resetn(resetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_alive_i(alive),
    .confirm_key_i(ok_key), .cancel_key_i(x_key), .host_rst_i(rst_w),
    .host_rst_o(rst_o), .host_rst_oe(rst_oe), .power_sw_i(pwr_w),
    .power_sw_o(pwr_o), .power_sw_oe(pwr_oe), .display_blank(blank),
    .msg(msg), .self_reboot(reboot));
  apw_host_model i_host (.clk(clk), .rst_o(rst_o), .rst_oe(rst_oe), .pwr_o(pwr_o),
    .pwr_oe(pwr_oe), .on(on), .rst_w(rst_w), .pwr_w(pwr_w), .alive(alive),
    .rst_len(rst_len), .pwr_len(pwr_len), .rst_cnt(rst_cnt));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits on reset enable (0), power enable (1) or reboot pulse (2).
  task automatic waitf(input int s);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (n < 9000 && (s == 0 ? rst_oe : s == 1 ? pwr_oe : reboot) !== 1'b1);
    chk("wait", 1, n < 9000);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    apb(0, 8'h08, 32'h0);
    chk("cfg", 32'h2000, rd);
    apb(0, 8'h0c, 32'h0);
    chk("unmapped", 1, err);
    apb(0, 8'h04, 32'h0);
    chk("wd on", 0, rd[9]);
    apb(1, 8'h00, 32'h0204621c);
    apb(0, 8'h08, 32'h0);
    chk("cfg", 32'h0462, rd);
    ok_key <= 1'b1;
    waitf(1);
    ok_key <= 1'b0;
    chk("msg", APW_MSG_PON, msg);
    chk("pwr lvl", 0, pwr_o);
    waitf(2);
    chk("pwr len", 4 * TC, pwr_len);
    on <= 1'b1;
    ok_key <= 1'b1;
    repeat (100 * TC) @(posedge clk);
    ok_key <= 1'b0;
    repeat (4) @(posedge clk);
    ok_key <= 1'b1;
    waitf(0);
    chk("hold", 1, n > 120 * TC);
    chk("rst lvl", 1, rst_o);
    chk("msg", APW_MSG_RESET, msg);
    ok_key <= 1'b0;
    waitf(2);
    chk("rst len", 32 * TC, rst_len);
    apb(1, 8'h00, 32'h0100011d);
    waitf(0);
    chk("wd time", 1, n > 30 * TC && n < 34 * TC);
    apb(1, 8'h00, 32'h0100011d);
    apb(1, 8'h00, 32'h0100001d);
    apb(0, 8'h04, 32'h0);
    chk("wd off", 0, rd[9]);
    repeat (2000) @(posedge clk);
    chk("wd once", 2, rst_cnt);
    apb(1, 8'h00, 32'h0100851c);
    x_key <= 1'b1;
    waitf(1);
    chk("msg", APW_MSG_POFF, msg);
    chk("auto lvl", 0, pwr_o);
    repeat (8 * TC) @(posedge clk);
    chk("extend", 1, pwr_oe);
    x_key <= 1'b0;
    apb(1, 8'h00, 32'h0100101c);
    on <= 1'b0;
    repeat (6) @(posedge clk);
    chk("blank", 1, blank);
    on <= 1'b1;
    waitf(2);
    tally_and_finish;
  end
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
